// ===== inc/hwmon_pkg.sv
// Constants for the hardware monitor control core and its limit checker.
// Assumes one 10 MHz clock and an SMBus host clocking SCL well below it.
// Overview of operation
// - Config one bit 7 switches supply measurement scaling for a 5 V supply.
// - Five voltage-ID pins are sampled and readable in the voltage-ID register.
// - Low address-enable strap selects address mode; address-select pin picks address.
// - High address-enable strap gives the default slave address 0x5C.
// - In address mode, select low gives 0x58, select high gives 0x5A.
// - Slave address latches on first bus transaction; strap pins then resume fan use.
// - First written byte of every write loads the address pointer.
// - Once started, every channel is measured in turn and its value stored.
// - Each value is compared against limits; violations set status bits.
// - In alert mode, fan two pin is driven low while an unmasked status bit is set.
// - Masks gate only the alert output, never the status bits.
// - Fan two drive pin can be switched from PWM to alert output.
// - Signed offset register is added to each temperature reading.
// - Automatic fan control takes each fan start temperature from its register.
// - Automatic fan control takes each fan slope from its own register.
// - Each fan speed input can be switched to an analog input.
// - XOR test mode puts the XOR tree result on fan one drive pin.
package hwmon_pkg;
	localparam int CHANNELS = 8;
	localparam int TEMPS = 3;
	localparam int TEMP_FIRST = 5;
	localparam int FANS = 3;
	localparam logic [7:0] VALUE_BASE = 8'h20;
	localparam logic [7:0] LOW_BASE = 8'h30;
	localparam logic [7:0] HIGH_BASE = 8'h38;
	localparam logic [7:0] CONFIG_ONE = 8'h40;
	localparam logic [7:0] STATUS_REG = 8'h41;
	localparam logic [7:0] MASK_REG = 8'h42;
	localparam logic [7:0] VID_REG = 8'h43;
	localparam logic [7:0] CONFIG_TWO = 8'h44;
	localparam logic [7:0] OFFSET_BASE = 8'h48;
	localparam logic [7:0] FAN_START_TEMPERATURE_BASE = 8'h4C;
	localparam logic [7:0] FAN_TEMPERATURE_SLOPE_BASE = 8'h50;
	localparam int CFG1_START = 0;
	localparam int CFG1_AUTO_FAN = 1;
	localparam int CFG1_VCC_5V = 7;
	localparam int CFG2_ALERT = 0;
	localparam int CFG2_XOR = 1;
	localparam int CFG2_ANALOG_LSB = 4;
	localparam logic [7:0] ADDR_DEFAULT = 8'h5C;
	localparam logic [7:0] ADDR_SEL_LOW = 8'h58;
	localparam logic [7:0] ADDR_SEL_HIGH = 8'h5A;
	localparam logic [7:0] RESET_ZERO = 8'h00;
	localparam logic [7:0] RESET_HIGH_LIMIT = 8'hFF;
	localparam logic [7:0] RESET_FAN_START_TEMPERATURE = 8'h5A;
	localparam logic [7:0] RESET_FAN_TEMPERATURE_SLOPE = 8'h02;
	localparam logic [7:0] DUTY_FULL = 8'hFF;
	localparam logic [3:0] BYTE_BITS = 4'h8;
endpackage

// ===== inc/meas_if.sv
// Carries one measurement between the sequencer and the limit checker.
// Purely combinational; the checker answers in the same cycle.
interface meas_if;
	logic [7:0] raw;
	logic [7:0] offset;
	logic is_temp;
	logic [7:0] low;
	logic [7:0] high;
	logic [7:0] value;
	logic out_of_limit;
	modport seq (output raw, offset, is_temp, low, high, input value, out_of_limit);
	modport chk (input raw, offset, is_temp, low, high, output value, out_of_limit);
endinterface

// ===== verilog/limit_check.sv
// Offset correction and window comparison for one converted sample.
// Assumes temperatures are signed bytes and voltages unsigned bytes.
module limit_check (
	meas_if.chk m
);
	import hwmon_pkg::*;
	logic signed [8:0] sum;
	always_comb begin
		sum = $signed({m.raw[7], m.raw}) + $signed({m.offset[7], m.offset});
		m.value = m.raw;
		if (m.is_temp) begin
			if (sum > 9'sd127) begin
				m.value = 8'h7F;
			end else if (sum < -9'sd128) begin
				m.value = 8'h80;
			end else begin
				m.value = sum[7:0];
			end
		end
		if (m.is_temp) begin
			m.out_of_limit = ($signed(m.value) < $signed(m.low)) ||
				($signed(m.value) > $signed(m.high));
		end else begin
			m.out_of_limit = (m.value < m.low) || (m.value > m.high);
		end
	end
	// Window check assertion sits in the core, which owns the clock this checker lacks
endmodule

// ===== verilog/hw_monitor_control_core.sv
// Control core: SMBus slave, register file, measurement sequencer, alert and fan drive.
// Assumes an external converter that answers a start pulse with a done pulse on sys_clk.
module hw_monitor_control_core (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [4:0] cpu_voltage_code,
	input wire logic fan3_drive_in,
	input wire logic fan4_speed_input,
	input wire logic xor_chain_result,
	input wire logic [7:0] adc_result,
	input wire logic adc_done,
	output logic meas_start,
	output logic [2:0] meas_channel,
	output logic vcc_5v_scale,
	output logic [3:0] fan_tach_analog_sel,
	output logic fan1_drive_output,
	output logic fan1_drive_oe,
	output logic fan2_drive_output,
	output logic fan2_drive_oe,
	output logic fan3_drive_output,
	output logic fan3_drive_oe
);
	import hwmon_pkg::*;

	typedef enum logic [2:0] {B_IDLE, B_ADDR, B_ACK_ADDR, B_WRITE, B_ACK_WRITE, B_READ,
		B_ACK_READ} bus_state_t;
	typedef enum logic [1:0] {S_IDLE, S_START, S_WAIT} seq_state_t;

	logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
	logic [4:0] vid_m_q, vid_s_q, vid_q;
	logic strap_m_q, strap_s_q, sel_m_q, sel_s_q;
	logic addr_locked_q, strap_high_q;
	logic [7:0] my_addr_q;
	bus_state_t bstate_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q, tx_q, ptr_q, rd_data;
	logic first_byte_q, sda_oe_q, zero_q;
	logic [7:0] cfg1_q, cfg2_q, status_q, mask_q;
	logic [7:0] value_q [CHANNELS];
	logic [7:0] low_q [CHANNELS];
	logic [7:0] high_q [CHANNELS];
	logic [7:0] offset_q [TEMPS];
	logic [7:0] fan_start_temperature_q [TEMPS];
	logic [7:0] fan_temperature_slope_q [TEMPS];
	logic [7:0] duty_q [FANS];
	logic [7:0] pwm_cnt_q;
	seq_state_t sstate_q;
	logic [2:0] ch_q;
	logic meas_start_q, vcc_5v_q, alert_q;
	logic f1_oe_q, f2_oe_q, f3_oe_q;
	logic [3:0] analog_sel_q;
	logic scl_rise, scl_fall, start_cond, stop_cond, byte_end, reg_we, ptr_we, tx_load;
	logic status_clr, sample_done;
	logic [7:0] status_set;
	logic [1:0] tidx;
	meas_if m ();

	// Two flops on the bus, strap and voltage-ID pins before use; the XOR input is used unsynchronised
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			{scl_m_q, scl_s_q, scl_p_q} <= 3'b111;
			{sda_m_q, sda_s_q, sda_p_q} <= 3'b111;
			{strap_m_q, strap_s_q, sel_m_q, sel_s_q} <= 4'hF;
			vid_m_q <= 5'h00;
			vid_s_q <= 5'h00;
		end else begin
			{scl_m_q, scl_s_q, scl_p_q} <= {scl_in, scl_m_q, scl_s_q};
			{sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
			{strap_m_q, strap_s_q} <= {fan3_drive_in, strap_m_q};
			{sel_m_q, sel_s_q} <= {fan4_speed_input, sel_m_q};
			vid_m_q <= cpu_voltage_code;
			vid_s_q <= vid_m_q;
		end
	end

	assign scl_rise = scl_s_q & ~scl_p_q;
	assign scl_fall = ~scl_s_q & scl_p_q;
	assign start_cond = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	assign stop_cond = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
	assign byte_end = scl_fall && (bit_cnt_q == BYTE_BITS);
	assign ptr_we = (bstate_q == B_WRITE) && byte_end && first_byte_q;
	assign reg_we = (bstate_q == B_WRITE) && byte_end && !first_byte_q;
	assign tx_load = scl_fall && ((bstate_q == B_ACK_ADDR && shift_q[0]) ||
		(bstate_q == B_ACK_READ && !sda_oe_q && bit_cnt_q == 4'h0));
	assign status_clr = tx_load && (ptr_q == STATUS_REG);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_locked_q <= 1'b0;
			strap_high_q <= 1'b1;
			my_addr_q <= ADDR_DEFAULT;
		end else if (start_cond && !addr_locked_q) begin
			addr_locked_q <= 1'b1;
			strap_high_q <= strap_s_q;
			if (!strap_s_q) begin
				my_addr_q <= sel_s_q ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
			end else begin
				my_addr_q <= ADDR_DEFAULT;
			end
		end
	end

	// SMBus slave; bit_cnt stays 0 through B_ACK_READ, so the SCL fall there comes after the master ack bit
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bstate_q <= B_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= RESET_ZERO;
			tx_q <= RESET_ZERO;
			first_byte_q <= 1'b1;
			sda_oe_q <= 1'b0;
		end else if (start_cond) begin
			bstate_q <= B_ADDR;
			bit_cnt_q <= 4'h0;
			sda_oe_q <= 1'b0;
		end else if (stop_cond) begin
			bstate_q <= B_IDLE;
			sda_oe_q <= 1'b0;
		end else begin
			case (bstate_q)
				B_ADDR, B_WRITE: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_s_q};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (byte_end) begin
						if (bstate_q == B_WRITE || {shift_q[7:1], 1'b0} == my_addr_q) begin
							bstate_q <= (bstate_q == B_ADDR) ? B_ACK_ADDR : B_ACK_WRITE;
							sda_oe_q <= 1'b1;
							first_byte_q <= (bstate_q == B_ADDR);
						end else begin
							bstate_q <= B_IDLE;
						end
					end
				end
				B_ACK_ADDR, B_ACK_WRITE: begin
					if (scl_fall) begin
						bit_cnt_q <= 4'h0;
						if (bstate_q == B_ACK_ADDR && shift_q[0]) begin
							bstate_q <= B_READ;
							tx_q <= {rd_data[6:0], 1'b0};
							sda_oe_q <= ~rd_data[7];
						end else begin
							bstate_q <= B_WRITE;
							sda_oe_q <= 1'b0;
						end
					end
				end
				B_READ: begin
					if (scl_rise) begin
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (byte_end) begin
						bstate_q <= B_ACK_READ;
						bit_cnt_q <= 4'h0;
						sda_oe_q <= 1'b0;
					end else if (scl_fall) begin
						tx_q <= {tx_q[6:0], 1'b0};
						sda_oe_q <= ~tx_q[7];
					end
				end
				B_ACK_READ: begin
					if (scl_rise) begin
						// A high ack bit is the master's no-acknowledge
						bstate_q <= sda_s_q ? B_IDLE : B_ACK_READ;
					end else if (tx_load) begin
						bstate_q <= B_READ;
						tx_q <= {rd_data[6:0], 1'b0};
						sda_oe_q <= ~rd_data[7];
					end
				end
				default: begin
					bstate_q <= B_IDLE;
				end
			endcase
		end
	end

	// Pointer-selected read data; unmapped addresses read zero
	always_comb begin
		rd_data = RESET_ZERO;
		tidx = ptr_q[1:0];
		if (ptr_q[7:3] == VALUE_BASE[7:3]) begin
			rd_data = value_q[ptr_q[2:0]];
		end else if (ptr_q[7:3] == LOW_BASE[7:3]) begin
			rd_data = low_q[ptr_q[2:0]];
		end else if (ptr_q[7:3] == HIGH_BASE[7:3]) begin
			rd_data = high_q[ptr_q[2:0]];
		end else if (ptr_q == CONFIG_ONE) begin
			rd_data = cfg1_q;
		end else if (ptr_q == STATUS_REG) begin
			rd_data = status_q;
		end else if (ptr_q == MASK_REG) begin
			rd_data = mask_q;
		end else if (ptr_q == VID_REG) begin
			rd_data = {3'b000, vid_q};
		end else if (ptr_q == CONFIG_TWO) begin
			rd_data = cfg2_q;
		end else if (tidx != 2'b11 && ptr_q[7:2] == OFFSET_BASE[7:2]) begin
			rd_data = offset_q[tidx];
		end else if (tidx != 2'b11 && ptr_q[7:2] == FAN_START_TEMPERATURE_BASE[7:2]) begin
			rd_data = fan_start_temperature_q[tidx];
		end else if (tidx != 2'b11 && ptr_q[7:2] == FAN_TEMPERATURE_SLOPE_BASE[7:2]) begin
			rd_data = fan_temperature_slope_q[tidx];
		end
	end

	// Register file writes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q <= RESET_ZERO;
			cfg1_q <= RESET_ZERO;
			cfg2_q <= RESET_ZERO;
			mask_q <= RESET_ZERO;
			vid_q <= 5'h00;
			for (int i = 0; i < CHANNELS; i++) begin
				low_q[i] <= RESET_ZERO;
				high_q[i] <= RESET_HIGH_LIMIT;
			end
			for (int i = 0; i < TEMPS; i++) begin
				offset_q[i] <= RESET_ZERO;
				fan_start_temperature_q[i] <= RESET_FAN_START_TEMPERATURE;
				fan_temperature_slope_q[i] <= RESET_FAN_TEMPERATURE_SLOPE;
			end
		end else begin
			vid_q <= vid_s_q;
			if (ptr_we) begin
				ptr_q <= shift_q;
			end
			if (reg_we) begin
				if (ptr_q[7:3] == LOW_BASE[7:3]) begin
					low_q[ptr_q[2:0]] <= shift_q;
				end else if (ptr_q[7:3] == HIGH_BASE[7:3]) begin
					high_q[ptr_q[2:0]] <= shift_q;
				end else if (ptr_q == CONFIG_ONE) begin
					cfg1_q <= shift_q;
				end else if (ptr_q == MASK_REG) begin
					mask_q <= shift_q;
				end else if (ptr_q == CONFIG_TWO) begin
					cfg2_q <= shift_q;
				end else if (tidx != 2'b11 && ptr_q[7:2] == OFFSET_BASE[7:2]) begin
					offset_q[tidx] <= shift_q;
				end else if (tidx != 2'b11 && ptr_q[7:2] == FAN_START_TEMPERATURE_BASE[7:2]) begin
					fan_start_temperature_q[tidx] <= shift_q;
				end else if (tidx != 2'b11 && ptr_q[7:2] == FAN_TEMPERATURE_SLOPE_BASE[7:2]) begin
					fan_temperature_slope_q[tidx] <= shift_q;
				end
			end
		end
	end

	assign m.raw = adc_result;
	assign m.is_temp = (ch_q >= 3'(TEMP_FIRST));
	assign m.offset = m.is_temp ? offset_q[2'(ch_q - 3'(TEMP_FIRST))] : RESET_ZERO;
	assign m.low = low_q[ch_q];
	assign m.high = high_q[ch_q];
	assign sample_done = (sstate_q == S_WAIT) && adc_done;
	assign status_set = (sample_done && m.out_of_limit) ? (8'h01 << ch_q) : RESET_ZERO;

	limit_check chk_u (
		.m(m)
	);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sstate_q <= S_IDLE;
			ch_q <= 3'h0;
			meas_start_q <= 1'b0;
			for (int i = 0; i < CHANNELS; i++) begin
				value_q[i] <= RESET_ZERO;
			end
		end else begin
			meas_start_q <= 1'b0;
			case (sstate_q)
				S_IDLE: begin
					if (cfg1_q[CFG1_START]) begin
						sstate_q <= S_START;
					end
				end
				S_START: begin
					meas_start_q <= 1'b1;
					sstate_q <= S_WAIT;
				end
				S_WAIT: begin
					if (adc_done) begin
						value_q[ch_q] <= m.value;
						ch_q <= ch_q + 3'h1;
						sstate_q <= cfg1_q[CFG1_START] ? S_START : S_IDLE;
					end
				end
				default: begin
					sstate_q <= S_IDLE;
				end
			endcase
		end
	end

	// Sticky status; a new event beats the read clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= RESET_ZERO;
			alert_q <= 1'b0;
		end else begin
			status_q <= (status_clr ? RESET_ZERO : status_q) | status_set;
			alert_q <= cfg2_q[CFG2_ALERT] && |(status_q & ~mask_q);
		end
	end

	// Automatic duty from start temperature and slope
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_cnt_q <= RESET_ZERO;
			for (int i = 0; i < FANS; i++) begin
				duty_q[i] <= DUTY_FULL;
			end
		end else begin
			pwm_cnt_q <= pwm_cnt_q + 8'h01;
			for (int i = 0; i < FANS; i++) begin
				if (!cfg1_q[CFG1_AUTO_FAN]) begin
					duty_q[i] <= DUTY_FULL;
				end else if ($signed(value_q[TEMP_FIRST + i]) <= $signed(fan_start_temperature_q[i])) begin
					duty_q[i] <= RESET_ZERO;
				end else if (|((16'(8'(value_q[TEMP_FIRST + i] - fan_start_temperature_q[i])) <<
					fan_temperature_slope_q[i][2:0]) >> 8)) begin
					duty_q[i] <= DUTY_FULL;
				end else begin
					duty_q[i] <= 8'(value_q[TEMP_FIRST + i] - fan_start_temperature_q[i]) << fan_temperature_slope_q[i][2:0];
				end
			end
		end
	end

	// Open-drain pins: enable high pulls the pin low
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			zero_q <= 1'b0;
			f1_oe_q <= 1'b0;
			f2_oe_q <= 1'b0;
			f3_oe_q <= 1'b0;
			vcc_5v_q <= 1'b0;
			analog_sel_q <= 4'h0;
		end else begin
			zero_q <= 1'b0;
			vcc_5v_q <= cfg1_q[CFG1_VCC_5V];
			analog_sel_q <= cfg2_q[CFG2_ANALOG_LSB +: 4];
			f1_oe_q <= cfg2_q[CFG2_XOR] ? ~xor_chain_result : ~(pwm_cnt_q < duty_q[0]);
			f2_oe_q <= cfg2_q[CFG2_ALERT] ? alert_q : ~(pwm_cnt_q < duty_q[1]);
			// Strap pin stays released until the address is latched
			f3_oe_q <= addr_locked_q && !(pwm_cnt_q < duty_q[2]);
		end
	end

	assign sda_out = zero_q;
	assign sda_oe = sda_oe_q;
	assign meas_start = meas_start_q;
	assign meas_channel = ch_q;
	assign vcc_5v_scale = vcc_5v_q;
	assign fan_tach_analog_sel = analog_sel_q;
	assign fan1_drive_output = zero_q;
	assign fan1_drive_oe = f1_oe_q;
	assign fan2_drive_output = zero_q;
	assign fan2_drive_oe = f2_oe_q;
	assign fan3_drive_output = zero_q;
	assign fan3_drive_oe = f3_oe_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	limit_window_a: assert property (!m.is_temp |-> m.value == m.raw &&
		m.out_of_limit == ((m.raw < m.low) || (m.raw > m.high)))
		else $error("voltage window compare wrong");
	scale_follow_a: assert property (##1 vcc_5v_q == $past(cfg1_q[CFG1_VCC_5V]))
		else $error("supply scaling not following config");
	vid_readback_a: assert property ($stable(cpu_voltage_code)[*4] |-> vid_q == cpu_voltage_code)
		else $error("voltage-ID register stale");
	addr_select_a: assert property (addr_locked_q && !strap_high_q |->
		(my_addr_q == ADDR_SEL_LOW || my_addr_q == ADDR_SEL_HIGH))
		else $error("address select mode gave wrong address");
	addr_default_a: assert property (addr_locked_q && strap_high_q |-> my_addr_q == ADDR_DEFAULT)
		else $error("default address wrong");
	addr_hold_a: assert property (addr_locked_q |=> addr_locked_q && $stable(my_addr_q))
		else $error("slave address changed after latch");
	ptr_load_a: assert property (ptr_we |=> ptr_q == $past(shift_q))
		else $error("pointer not loaded from first byte");
	value_store_a: assert property (sample_done |=> value_q[$past(ch_q)] == $past(m.value))
		else $error("sample not stored");
	status_set_a: assert property (sample_done && m.out_of_limit |=> status_q[$past(ch_q)])
		else $error("out-of-limit not flagged");
	status_sticky_a: assert property (status_q != 8'h00 && !status_clr |=>
		(status_q & $past(status_q)) == $past(status_q))
		else $error("status bit dropped without read");
	mask_alert_a: assert property (##1 alert_q ==
		$past(cfg2_q[CFG2_ALERT] && |(status_q & ~mask_q)))
		else $error("alert does not follow masked status");
	alert_pin_a: assert property (cfg2_q[CFG2_ALERT] && alert_q |=> f2_oe_q)
		else $error("alert not driven on fan two pin");
	xor_mode_a: assert property (cfg2_q[CFG2_XOR] |=> f1_oe_q == !$past(xor_chain_result))
		else $error("xor result not on fan one pin");
endmodule

// ===== bench/smbus_host.sv
// SMBus host model: drives SCL and pulls SDA low, stepped on sys_clk.
// Assumes the bench resolves SDA from both pull-downs and a pull-up.
module smbus_host (
	input wire logic sys_clk,
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	// Quarter bit time; long enough for the slave's synchronisers and answer delay
	localparam int Q = 6;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic start_c();
		tick(2 * Q);
		sda_low <= 1'b1;
		tick(2 * Q);
		scl <= 1'b0;
	endtask
	task automatic stop_c();
		tick(Q);
		sda_low <= 1'b1;
		tick(Q);
		scl <= 1'b1;
		tick(2 * Q);
		sda_low <= 1'b0;
		tick(2 * Q);
	endtask
	task automatic bit_out(input logic b);
		tick(Q);
		sda_low <= ~b;
		tick(Q);
		scl <= 1'b1;
		tick(2 * Q);
		scl <= 1'b0;
	endtask
	task automatic bit_in(output logic b);
		tick(Q);
		sda_low <= 1'b0;
		tick(Q);
		scl <= 1'b1;
		tick(Q);
		b = sda;
		tick(Q);
		scl <= 1'b0;
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic nb;
		for (int i = 7; i >= 0; i--) bit_out(d[i]);
		bit_in(nb);
		ack = ~nb;
	endtask
	task automatic wr(input logic [7:0] adr, input logic [7:0] ptr, input logic [7:0] d,
		input logic with_data, output logic ack);
		logic a;
		start_c();
		send(adr, ack);
		if (ack) send(ptr, a);
		if (ack && with_data) send(d, a);
		stop_c();
	endtask
	task automatic rd(input logic [7:0] adr, output logic [7:0] d);
		logic a;
		start_c();
		send(adr | 8'h01, a);
		for (int i = 7; i >= 0; i--) bit_in(d[i]);
		// Not acknowledging ends the read
		bit_out(1'b1);
		stop_c();
	endtask
endmodule

// ===== bench/hw_monitor_control_core_tb_top.sv
// Self-checking bench for the monitor control core, SMBus host and converter stand-in.
// Assumes pull-ups on SDA and the strap pin; the converter answers in four cycles.
module hw_monitor_control_core_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import hwmon_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n, scl, host_low, sda, sda_out, sda_oe, strap_en, strap_sel, xor_in;
	logic adc_done, meas_start, vcc_5v_scale, fan3_pin, f1o, f1oe, f2o, f2oe, f3o, f3oe;
	logic [4:0] cpu_voltage_id_readback;
	logic [7:0] adc_result;
	logic [2:0] meas_channel, adc_ch;
	logic [3:0] analog_sel;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	int adc_wait = 0;
	int val[8];
	int regm[256];
	int written[$];
	always #50 sys_clk = ~sys_clk;
	assign sda = ~(host_low | sda_oe);
	assign fan3_pin = strap_en & ~f3oe;
	smbus_host host (.sys_clk(sys_clk), .scl(scl), .sda_low(host_low), .sda(sda));
	hw_monitor_control_core DUT (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .cpu_voltage_code(cpu_voltage_id_readback),
		.fan3_drive_in(fan3_pin), .fan4_speed_input(strap_sel), .xor_chain_result(xor_in),
		.adc_result(adc_result), .adc_done(adc_done), .meas_start(meas_start),
		.meas_channel(meas_channel), .vcc_5v_scale(vcc_5v_scale),
		.fan_tach_analog_sel(analog_sel), .fan1_drive_output(f1o), .fan1_drive_oe(f1oe),
		.fan2_drive_output(f2o), .fan2_drive_oe(f2oe), .fan3_drive_output(f3o),
		.fan3_drive_oe(f3oe));
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		adc_done <= 1'b0;
		if (meas_start) begin
			adc_ch <= meas_channel;
			adc_wait <= 4;
		end else if (adc_wait > 0) begin
			adc_wait <= adc_wait - 1;
			if (adc_wait == 1) begin
				adc_done <= 1'b1;
				adc_result <= 8'(val[adc_ch]);
			end
		end
	end
	// Whole run needs about 31000 cycles
	always @(posedge sys_clk) begin
		if (cycles == 80000) begin
			miscompares++;
			conclude();
		end
	end
	function automatic int sx(int b);
		return (b > 127) ? b - 256 : b;
	endfunction
	function automatic int exp_val(int ch);
		int r;
		r = val[ch];
		if (ch >= TEMP_FIRST) begin
			r = sx(r) + sx(regm[OFFSET_BASE + ch - TEMP_FIRST]);
			r = (r > 127) ? 127 : ((r < -128) ? -128 : r);
		end
		return r & 255;
	endfunction
	function automatic int exp_status();
		int s, v, lo, hi;
		s = 0;
		for (int ch = 0; ch < CHANNELS; ch++) begin
			v = exp_val(ch);
			lo = regm[LOW_BASE + ch];
			hi = regm[HIGH_BASE + ch];
			if (ch >= TEMP_FIRST) begin
				v = sx(v);
				lo = sx(lo);
				hi = sx(hi);
			end
			if (v < lo || v > hi) s |= 1 << ch;
		end
		return s;
	endfunction
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wreg(input int ptr, input int d);
		logic a;
		regm[ptr] = d;
		written.push_back(ptr);
		host.wr(ADDR_DEFAULT, 8'(ptr), 8'(d), 1'b1, a);
		chk("write ack", 8'h01, {7'h00, a});
	endtask
	task automatic rreg(input int ptr, input int e);
		logic a;
		logic [7:0] d;
		host.wr(ADDR_DEFAULT, 8'(ptr), 8'h00, 1'b0, a);
		host.rd(ADDR_DEFAULT, d);
		chk("register read", 8'(e), d);
	endtask
	task automatic do_reset();
		for (int i = 0; i < 256; i++) regm[i] = (i >= HIGH_BASE && i < HIGH_BASE + 8) ? 255 : 0;
		rst_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		logic a;
		logic [7:0] d;
		logic [7:0] adr [3];
		rst_n = 1'b0;
		strap_en = 1'b1;
		strap_sel = 1'b0;
		xor_in = 1'b0;
		cpu_voltage_id_readback = 5'h00;
		adc_done = 1'b0;
		adc_result = 8'h00;
		adr[0] = ADDR_SEL_LOW;
		adr[1] = ADDR_SEL_HIGH;
		adr[2] = ADDR_DEFAULT;
		void'($urandom(70219));
		for (int i = 0; i < 8; i++) val[i] = (i >= TEMP_FIRST) ? $urandom_range(16, 80) : $urandom_range(16, 239);
		for (int k = 0; k < 3; k++) begin
			strap_en <= (k == 2);
			strap_sel <= (k == 1);
			cpu_voltage_id_readback <= 5'($urandom);
			do_reset();
			chk("strap pin released", 8'h00, {7'h00, f3oe});
			host.wr(adr[(k + 1) % 3], VID_REG, 8'h00, 1'b0, a);
			chk("foreign address ack", 8'h00, {7'h00, a});
			// Straps move after the first transaction; the latched address must not
			strap_en <= (k != 2);
			strap_sel <= (k != 1);
			host.wr(adr[k], VID_REG, 8'h00, 1'b0, a);
			chk("own address ack", 8'h01, {7'h00, a});
			host.rd(adr[k], d);
			chk("voltage code", {3'b000, cpu_voltage_id_readback}, d);
			$display("address test %0d done", k);
		end
		// Limits first: monitoring starts last so no stale status appears
		wreg(HIGH_BASE + 1, val[1] - 1);
		wreg(LOW_BASE, val[0] + 1);
		wreg(HIGH_BASE + 6, 8'h7F);
		wreg(OFFSET_BASE, 8'hFE);
		wreg(CONFIG_TWO, 8'hA0);
		wreg(CONFIG_ONE, 8'h81);
		foreach (written[i]) rreg(written[i], regm[written[i]]);
		host.wr(ADDR_DEFAULT, VID_REG, 8'h15, 1'b1, a);
		rreg(VID_REG, cpu_voltage_id_readback);
		rreg(8'h7F, 0);
		chk("supply scale", 8'h01, {7'h00, vcc_5v_scale});
		chk("analog select", 8'h0A, {4'h0, analog_sel});
		chk("pin drive level", 8'h00, {4'h0, sda_out, f1o, f2o, f3o});
		$display("register test done");
		repeat (200) @(posedge sys_clk);
		for (int ch = 0; ch < CHANNELS; ch++) rreg(VALUE_BASE + ch, exp_val(ch));
		rreg(STATUS_REG, exp_status());
		$display("measurement test done");
		wreg(MASK_REG, 8'hFF);
		wreg(CONFIG_TWO, 8'hA1);
		repeat (4) @(posedge sys_clk);
		chk("alert masked", 8'h00, {7'h00, f2oe});
		wreg(MASK_REG, 8'hFD);
		repeat (4) @(posedge sys_clk);
		chk("alert driven", 8'h01, {7'h00, f2oe});
		wreg(CONFIG_ONE, 8'h80);
		repeat (50) @(posedge sys_clk);
		rreg(STATUS_REG, exp_status());
		rreg(STATUS_REG, 0);
		repeat (4) @(posedge sys_clk);
		chk("alert released", 8'h00, {7'h00, f2oe});
		$display("alert test done");
		wreg(CONFIG_TWO, 8'h02);
		for (int b = 0; b < 2; b++) begin
			xor_in <= 1'(b);
			repeat (4) @(posedge sys_clk);
			chk("xor pin pull", 8'(1 - b), {7'h00, f1oe});
		end
		$display("xor test done");
		conclude();
	end
endmodule
